// >>> logic/drive_peer_reference_link.sv
/*
 * Peer reference link between drives: master sends its reference
 * periodically, slave scales, clamps and uses it, with link loss and
 * runaway supervision.
 * Assumes frame transport is done outside; frames arrive as one-cycle strobes.
 */
// Strobed register access and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module drive_peer_reference_link
    import peer_link_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES, // Cycles per millisecond tick.
    parameter int TX_WIDTH = 16 // Reference width.
)
(
    input wire logic sys_clk_in, // System clock, 100 MHz.
    input wire logic sys_rst_in, // Synchronous reset, high.
    input wire logic [3:0] reg_addr_in, // Register index.
    input wire logic [15:0] reg_wdata_in, // Write data.
    input wire logic reg_wr_in, // Write strobe.
    input wire logic reg_rd_in, // Read strobe.
    output logic [15:0] reg_rdata_out, // Read data, one cycle later.
    input wire logic signed [TX_WIDTH-1:0] local_freq_in, // Own frequency, 0.01 % of max.
    input wire logic signed [TX_WIDTH-1:0] local_torque_in, // Own torque, 0.01 %.
    input wire logic local_run_in, // Own run command.
    input wire logic rx_valid_in, // Valid frame from master.
    input wire peer_frame_t rx_frame_in, // Received frame.
    output logic tx_valid_out, // Frame send strobe.
    output peer_frame_t tx_frame_out, // Frame to send.
    output logic [7:0] node_addr_out, // Own link address.
    output logic signed [15:0] torque_ref_out, // Torque reference, 0.1 %.
    output logic torque_ref_valid_out, // Torque reference in use.
    output logic [31:0] freq_ref_out, // Frequency reference, 0.01 Hz.
    output logic freq_ref_valid_out, // Frequency reference in use.
    output logic follow_run_out, // Run command taken from master.
    output logic follow_active_out, // Run follows master.
    output logic link_fault_out, // Link interruption fault.
    output logic runaway_fault_out // Runaway detected.
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] ctrl_q, torque_offset_q, torque_gain_q, loss_timeout_q;
    logic [15:0] send_period_q, freq_offset_q, freq_gain_q, runaway_q, max_freq_q;

    function automatic logic [15:0] clamp_s(input logic [15:0] v, input logic signed [15:0] lim);
        logic signed [15:0] s;
        s = v;
        clamp_s = (s > lim) ? lim : (s < -lim) ? -lim : v;
    endfunction : clamp_s

    function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        clamp_u = (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction : clamp_u

    wire logic wr_ctrl = reg_wr_in && (reg_addr_in == REG_CTRL);
    wire logic wr_toff = reg_wr_in && (reg_addr_in == REG_TORQUE_OFFSET);
    wire logic wr_tgain = reg_wr_in && (reg_addr_in == REG_TORQUE_GAIN);
    wire logic wr_loss = reg_wr_in && (reg_addr_in == REG_LOSS_TIMEOUT);
    wire logic wr_period = reg_wr_in && (reg_addr_in == REG_SEND_PERIOD);
    wire logic wr_foff = reg_wr_in && (reg_addr_in == REG_FREQ_OFFSET);
    wire logic wr_fgain = reg_wr_in && (reg_addr_in == REG_FREQ_GAIN);
    wire logic wr_runaway = reg_wr_in && (reg_addr_in == REG_RUNAWAY);
    wire logic wr_maxf = reg_wr_in && (reg_addr_in == REG_MAX_FREQ);

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_q <= 16'h0000; // [R1]
            torque_offset_q <= RST_TORQUE_OFFSET;
            torque_gain_q <= RST_GAIN;
            loss_timeout_q <= RST_LOSS_TIMEOUT;
            send_period_q <= RST_SEND_PERIOD;
            freq_offset_q <= RST_TORQUE_OFFSET;
            freq_gain_q <= RST_GAIN;
            runaway_q <= RST_RUNAWAY;
            max_freq_q <= RST_MAX_FREQ;
        end
        else
        begin
            if (wr_ctrl) ctrl_q <= {7'h00, reg_wdata_in[8:0]};
            if (wr_toff) torque_offset_q <= clamp_s(reg_wdata_in, PCT_FULL);
            if (wr_tgain) torque_gain_q <= clamp_s(reg_wdata_in, GAIN_LIMIT);
            if (wr_loss) loss_timeout_q <= clamp_u(reg_wdata_in, 16'h0000, LOSS_TIMEOUT_MAX);
            if (wr_period) send_period_q <= clamp_u(reg_wdata_in, 16'h0001, SEND_PERIOD_MAX); // [R14]
            if (wr_foff) freq_offset_q <= clamp_s(reg_wdata_in, PCT_FULL); // [R10]
            if (wr_fgain) freq_gain_q <= clamp_s(reg_wdata_in, GAIN_LIMIT);
            if (wr_runaway) runaway_q <= clamp_u(reg_wdata_in, 16'h0000, 16'(PCT_FULL));
            if (wr_maxf) max_freq_q <= reg_wdata_in;
        end
    end

    link_ctrl_t ctl;
    assign ctl.enable = ctrl_q[CTRL_ENABLE_BIT];
    assign ctl.role_slave = ctrl_q[CTRL_ROLE_BIT];
    assign ctl.follow = ctrl_q[CTRL_FOLLOW_BIT];
    assign ctl.usage_freq = ctrl_q[CTRL_USAGE_BIT];
    assign ctl.cmd_src = ctrl_q[CTRL_CMDSRC_LSB +: 2];
    assign ctl.freq_comm = ctrl_q[CTRL_FREQ_COMM_BIT];
    assign ctl.torque_comm = ctrl_q[CTRL_TORQUE_COMM_BIT];
    assign ctl.torque_mode = ctrl_q[CTRL_TORQUE_MODE_BIT];

    wire logic is_master = ctl.enable && !ctl.role_slave; // [R1]
    wire logic is_slave = ctl.enable && ctl.role_slave; // [R1]

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_q;
    wire logic tick = (tick_cnt_q == 32'(TICK_CYC - 1));

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || tick)
            tick_cnt_q <= 32'h0000_0000;
        else
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end

    // ------------------------------------------------------------
    // Master transmit
    // ------------------------------------------------------------
    logic [15:0] send_cnt_q;
    wire logic send_now = is_master && tick && (send_cnt_q + 16'h0001 >= send_period_q); // [R14]
    wire logic signed [15:0] tx_value = ctl.torque_mode ? 16'(local_torque_in) : 16'(local_freq_in);

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || !is_master || send_now)
            send_cnt_q <= 16'h0000;
        else if (tick)
            send_cnt_q <= send_cnt_q + 16'h0001;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            tx_valid_out <= 1'b0;
            tx_frame_out <= '0;
        end
        else
        begin
            tx_valid_out <= send_now;
            if (send_now)
                tx_frame_out <= '{value: tx_value, run: local_run_in}; // [R2]
        end
    end

    assign node_addr_out = ctl.role_slave ? NODE_SLAVE : NODE_MASTER; // [R3]

    // ------------------------------------------------------------
    // Slave receive and scaling
    // ------------------------------------------------------------
    wire logic rx_take = is_slave && rx_valid_in;
    logic signed [15:0] rx_value_q;
    logic rx_run_q;
    logic rx_seen_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || !is_slave)
        begin
            rx_value_q <= 16'sh0000;
            rx_run_q <= 1'b0;
            rx_seen_q <= 1'b0;
        end
        else if (rx_take)
        begin
            rx_value_q <= rx_frame_in.value;
            rx_run_q <= rx_frame_in.run;
            rx_seen_q <= 1'b1;
        end
    end

    wire logic signed [15:0] torque_y, freq_y;

    peer_ref_scaler torque_scaler (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .x_in(rx_value_q),
        .gain_in(torque_gain_q),
        .offset_in(torque_offset_q),
        .y_out(torque_y)
    ); // [R9] [R12]

    peer_ref_scaler freq_scaler (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .x_in(rx_value_q),
        .gain_in(freq_gain_q),
        .offset_in(freq_offset_q),
        .y_out(freq_y)
    ); // [R10]

    wire logic torque_use = is_slave && !ctl.usage_freq && ctl.torque_comm && rx_seen_q; // [R5] [R6]
    wire logic freq_use = is_slave && ctl.usage_freq && ctl.freq_comm && rx_seen_q; // [R5] [R6]
    wire logic signed [15:0] torque_scaled = 16'(torque_y / 16'sd10 * 16'(TORQUE_SCALE)); // [R7]
    wire logic signed [31:0] freq_signed = 32'(freq_y) * $signed(32'(max_freq_q)) / 32'sd10000; // [R8]

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            torque_ref_out <= 16'sh0000;
            freq_ref_out <= 32'h0000_0000;
        end
        else
        begin
            torque_ref_out <= torque_use ? torque_scaled : 16'sh0000;
            freq_ref_out <= freq_use ? freq_signed : 32'h0000_0000;
        end
    end

    assign torque_ref_valid_out = torque_use;
    assign freq_ref_valid_out = freq_use;

    // ------------------------------------------------------------
    // Run command following
    // ------------------------------------------------------------
    assign follow_active_out = is_slave && (ctl.cmd_src == CMDSRC_COMM) && ctl.follow; // [R4]

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
            follow_run_out <= 1'b0;
        else
            follow_run_out <= follow_active_out && rx_run_q && !link_fault_out; // [R4]
    end

    // ------------------------------------------------------------
    // Link loss supervision
    // ------------------------------------------------------------
    logic [31:0] loss_ms_q;
    wire logic [31:0] loss_limit = 32'(loss_timeout_q) * 32'(LOSS_STEP_MS);
    wire logic loss_armed = is_slave && (loss_timeout_q != 16'h0000); // [R13]

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || !loss_armed || rx_take)
            loss_ms_q <= 32'h0000_0000; // [R17]
        else if (tick && (loss_ms_q < loss_limit))
            loss_ms_q <= loss_ms_q + 32'h0000_0001;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || !loss_armed)
            link_fault_out <= 1'b0;
        else if (loss_ms_q >= loss_limit)
            link_fault_out <= 1'b1; // [R13] [R17]
    end

    // ------------------------------------------------------------
    // Runaway guard
    // ------------------------------------------------------------
    wire logic guard_on = torque_use && ctl.torque_mode && (runaway_q != 16'h0000); // [R15] [R16]
    wire logic signed [16:0] speed_diff = 17'(local_freq_in) - 17'(rx_value_q);
    wire logic [16:0] speed_abs = speed_diff[16] ? 17'(-speed_diff) : 17'(speed_diff);

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || !guard_on)
            runaway_fault_out <= 1'b0;
        else if (speed_abs > 17'(runaway_q))
            runaway_fault_out <= 1'b1; // [R16]
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    wire logic [15:0] status_word = {11'h000, runaway_fault_out, link_fault_out, follow_run_out,
                                     rx_seen_q, is_master};
    logic [15:0] rd_mux;

    always_comb
    begin
        case (reg_addr_in)
            REG_CTRL: rd_mux = ctrl_q;
            REG_TORQUE_OFFSET: rd_mux = torque_offset_q;
            REG_TORQUE_GAIN: rd_mux = torque_gain_q;
            REG_LOSS_TIMEOUT: rd_mux = loss_timeout_q;
            REG_SEND_PERIOD: rd_mux = send_period_q;
            REG_FREQ_OFFSET: rd_mux = freq_offset_q;
            REG_FREQ_GAIN: rd_mux = freq_gain_q;
            REG_RUNAWAY: rd_mux = runaway_q;
            REG_MAX_FREQ: rd_mux = max_freq_q;
            REG_STATUS: rd_mux = status_word;
            REG_REF_OUT: rd_mux = rx_value_q;
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= 16'h0000;
        else
            reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0000;
    end

endmodule : drive_peer_reference_link
`default_nettype wire

// >>> logic/peer_link_pkg.sv
/*
 * Constants and carrier types for the drive peer reference link.
 * Assumes a single 100 MHz clock and a plain register port of its own.
 */
// How it works
// R1: The link runs only while the link enable setting is 1; at its default of 0 the link is idle.
// R2: A master sends its own frequency or torque as the target value to every slave.
// R3: The node address follows the role setting, 1 for master and 2 for slave, with no manual address.
// R4: A slave with command source 2 and follow setting 1 starts and stops with the master's run command.
// R5: A slave routes received data to torque when usage is 0 and to frequency when usage is 1.
// R6: Received data is used only when the matching frequency or torque source is set to communication.
// R7: In torque usage a received 100.00% means a torque reference of 200.0%, whatever the torque limit.
// R8: In frequency usage a received 100.00% means the configured maximum output frequency.
// R9: Torque usage computes gain times received plus offset, gain -10.00 to 10.00 default 1.00, offset 0.00%.
// R10: Frequency usage has its own gain and offset pair of the same form, offset within +-100.00%, gain 1.00.
// R11: The result of gain and offset is saturated to -100.00%..100.00%.
// R12: With zero offset and unity gain a torque slave uses the master torque directly.
// R13: A link fault is raised after the link is silent for the set time, 0.0 to 10.0 s, default 1.0 s, 0 disables.
// R14: A master sends periodically, every 0.001 s to 10.000 s, default 0.001 s.
// R15: Runaway protection acts only for a torque-controlled slave following the master torque.
// R16: A runaway coefficient of 0.00% disables protection; other values (default 10.00%) enable it.
// R17: The silence timer restarts on every valid frame and the fault is declared when it reaches the set time.
package peer_link_pkg;

    // Register indices (word addresses on the register port).
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TORQUE_OFFSET = 4'h1;
    localparam logic [3:0] REG_TORQUE_GAIN = 4'h2;
    localparam logic [3:0] REG_LOSS_TIMEOUT = 4'h3;
    localparam logic [3:0] REG_SEND_PERIOD = 4'h4;
    localparam logic [3:0] REG_FREQ_OFFSET = 4'h5;
    localparam logic [3:0] REG_FREQ_GAIN = 4'h6;
    localparam logic [3:0] REG_RUNAWAY = 4'h7;
    localparam logic [3:0] REG_MAX_FREQ = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;
    localparam logic [3:0] REG_REF_OUT = 4'ha;

    // Control register field positions.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_ROLE_BIT = 1;
    localparam int CTRL_FOLLOW_BIT = 2;
    localparam int CTRL_USAGE_BIT = 3;
    localparam int CTRL_CMDSRC_LSB = 4;
    localparam int CTRL_FREQ_COMM_BIT = 6;
    localparam int CTRL_TORQUE_COMM_BIT = 7;
    localparam int CTRL_TORQUE_MODE_BIT = 8;

    // Reset values. Percent values are in 0.01 % units, gains in 0.01 units.
    localparam logic [15:0] RST_TORQUE_OFFSET = 16'h0000;
    localparam logic [15:0] RST_GAIN = 16'h0064;
    localparam logic [15:0] RST_LOSS_TIMEOUT = 16'h000a;
    localparam logic [15:0] RST_SEND_PERIOD = 16'h0001;
    localparam logic [15:0] RST_RUNAWAY = 16'h03e8;
    localparam logic [15:0] RST_MAX_FREQ = 16'h1388;

    // Limits and encodings.
    localparam logic signed [15:0] PCT_FULL = 16'sh2710;
    localparam logic signed [15:0] GAIN_LIMIT = 16'sh03e8;
    localparam logic [15:0] LOSS_TIMEOUT_MAX = 16'h0064;
    localparam logic [15:0] SEND_PERIOD_MAX = 16'h2710;
    localparam logic [1:0] CMDSRC_COMM = 2'h2;
    localparam logic [7:0] NODE_MASTER = 8'h01;
    localparam logic [7:0] NODE_SLAVE = 8'h02;
    localparam int TORQUE_SCALE = 2;

    // Time bases: one millisecond tick, timeout counted in 0.1 s steps.
    localparam int CLK_HZ = 100000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int LOSS_STEP_MS = 100;

    typedef struct packed {
        logic signed [15:0] value;
        logic run;
    } peer_frame_t;

    typedef struct packed {
        logic enable;
        logic role_slave;
        logic follow;
        logic usage_freq;
        logic [1:0] cmd_src;
        logic freq_comm;
        logic torque_comm;
        logic torque_mode;
    } link_ctrl_t;

endpackage : peer_link_pkg

// >>> logic/peer_ref_scaler.sv
/*
 * Gain, offset and saturation stage for a received reference.
 * Assumes the gain and offset were already range-limited by the caller.
 */
`timescale 1ns/10ps
`default_nettype none
module peer_ref_scaler
    import peer_link_pkg::*;
(
    input wire logic sys_clk_in, // System clock.
    input wire logic sys_rst_in, // Synchronous reset, high.
    input wire logic signed [15:0] x_in, // Received value, 0.01 %.
    input wire logic signed [15:0] gain_in, // Gain, 0.01 units.
    input wire logic signed [15:0] offset_in, // Offset, 0.01 %.
    output logic signed [15:0] y_out // Saturated result, 0.01 %.
);

    wire logic signed [31:0] product = x_in * gain_in;
    wire logic signed [31:0] scaled = product / 32'sd100 + 32'(offset_in);
    wire logic signed [31:0] sat_hi = 32'(PCT_FULL);
    wire logic signed [31:0] sat_lo = -32'(PCT_FULL);
    wire logic signed [15:0] y_d = (scaled > sat_hi) ? PCT_FULL :
                                   (scaled < sat_lo) ? -PCT_FULL : scaled[15:0]; // [R11]

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
            y_out <= 16'sh0000;
        else
            y_out <= y_d; // [R9] [R10]
    end

endmodule : peer_ref_scaler
`default_nettype wire

// >>> tb/peer_link_assertions.sv
/*
 * Port-level checker for the peer reference link, bound to its top module.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module peer_link_assertions
    import peer_link_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES, // Cycles per millisecond tick.
    parameter int TX_WIDTH = 16 // Reference width.
)
(
    input wire logic sys_clk_in, // System clock.
    input wire logic sys_rst_in, // Synchronous reset.
    input wire logic tx_valid_out, // Frame send strobe.
    input wire peer_frame_t tx_frame_out, // Frame to send.
    input wire logic [7:0] node_addr_out, // Own link address.
    input wire logic signed [15:0] torque_ref_out, // Torque reference.
    input wire logic torque_ref_valid_out, // Torque reference in use.
    input wire logic freq_ref_valid_out, // Frequency reference in use.
    input wire logic follow_active_out, // Run follows master.
    input wire logic link_fault_out // Link fault.
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_tx_spacing;
        tx_valid_out |=> !tx_valid_out [*8];
    endproperty
    a_tx_spacing: assert property (p_tx_spacing) else $error("send strobes too close");
    property p_tx_hold;
        $changed(tx_frame_out) |-> tx_valid_out;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("frame changed without send");
    property p_slave_silent;
        node_addr_out == NODE_SLAVE && $past(node_addr_out) == NODE_SLAVE |-> !tx_valid_out;
    endproperty
    a_slave_silent: assert property (p_slave_silent) else $error("slave sent a frame");
    property p_node_addr;
        node_addr_out == NODE_MASTER || node_addr_out == NODE_SLAVE;
    endproperty
    a_node_addr: assert property (p_node_addr) else $error("bad node address");
    property p_ref_excl;
        !(torque_ref_valid_out && freq_ref_valid_out);
    endproperty
    a_ref_excl: assert property (p_ref_excl) else $error("both references in use");
    property p_torque_range;
        torque_ref_valid_out |-> torque_ref_out >= -16'sd2000 && torque_ref_out <= 16'sd2000;
    endproperty
    a_torque_range: assert property (p_torque_range) else $error("torque out of range");
    property p_follow_slave;
        follow_active_out |-> node_addr_out == NODE_SLAVE;
    endproperty
    a_follow_slave: assert property (p_follow_slave) else $error("master follows");
    property p_master_norefs;
        node_addr_out == NODE_MASTER |-> !torque_ref_valid_out && !freq_ref_valid_out;
    endproperty
    a_master_norefs: assert property (p_master_norefs) else $error("master uses link data");
    c_tx: cover property (tx_valid_out);
    c_follow: cover property (follow_active_out);
    c_fault: cover property (link_fault_out);
endmodule : peer_link_assertions
bind drive_peer_reference_link peer_link_assertions #(.TICK_CYC(TICK_CYC), .TX_WIDTH(TX_WIDTH))
    peer_link_assertions_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .tx_valid_out(tx_valid_out),
    .tx_frame_out(tx_frame_out), .node_addr_out(node_addr_out), .torque_ref_out(torque_ref_out),
    .torque_ref_valid_out(torque_ref_valid_out), .freq_ref_valid_out(freq_ref_valid_out),
    .follow_active_out(follow_active_out), .link_fault_out(link_fault_out));
`default_nettype wire

// >>> tb/peer_master_model.sv
/*
 * Behavioural master drive on the far side of the link: sends frames on request.
 * Assumes the caller spaces its calls as a real master would.
 */
`timescale 1ns/10ps
`default_nettype none
module peer_master_model
    import peer_link_pkg::*;
(
    input wire logic clk_in, // System clock.
    output logic valid_out, // Frame strobe.
    output peer_frame_t frame_out // Frame carried.
);
    // ------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------
    initial valid_out = 1'b0;
    initial frame_out = '0;
    // The frame lines show the inverse once released so stale data cannot pass.
    task automatic send(input logic signed [15:0] v, input logic r);
        @(posedge clk_in);
        valid_out <= 1'b1;
        frame_out <= '{value: v, run: r};
        @(posedge clk_in);
        valid_out <= 1'b0;
        frame_out <= ~frame_out;
    endtask : send
endmodule : peer_master_model
`default_nettype wire

// >>> tb/drive_peer_reference_link_tb_top.sv
/*
 * Self-checking bench for the peer reference link.
 * Assumes the package constants and a shortened millisecond tick.
 */
`timescale 1ns/10ps
`default_nettype none
module drive_peer_reference_link_tb_top;
    import peer_link_pkg::*;
    localparam int TICK = 10;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, lrun = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic signed [15:0] lfreq = 16'sh0000, ltorq = 16'sh0000, tref;
    peer_frame_t rxf, txf;
    logic rxv, txv, trefv, frefv, frun, fact, lfault, rfault;
    logic [7:0] node;
    logic [31:0] fref;
    int n_errors = 0, cmp_count = 0, n;
    logic [15:0] rst_exp [0:8] = '{16'h0000, RST_TORQUE_OFFSET, RST_GAIN, RST_LOSS_TIMEOUT, RST_SEND_PERIOD,
        16'h0000, RST_GAIN, RST_RUNAWAY, RST_MAX_FREQ};
    always #5 clk = ~clk;
    peer_master_model peer_master_model_i (.clk_in(clk), .valid_out(rxv), .frame_out(rxf));
    drive_peer_reference_link #(.TICK_CYC(TICK), .TX_WIDTH(16)) drive_peer_reference_link_i (
        .sys_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .local_freq_in(lfreq), .local_torque_in(ltorq),
        .local_run_in(lrun), .rx_valid_in(rxv), .rx_frame_in(rxf), .tx_valid_out(txv), .tx_frame_out(txf),
        .node_addr_out(node), .torque_ref_out(tref), .torque_ref_valid_out(trefv), .freq_ref_out(fref),
        .freq_ref_valid_out(frefv), .follow_run_out(frun), .follow_active_out(fact),
        .link_fault_out(lfault), .runaway_fault_out(rfault));
    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk({16'h0000, rdata}, {16'h0000, e});
    endtask : rd_chk
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wait_tx(output int k);
        k = 0;
        do cyc(1); while (txv !== 1'b1 && ++k < 300);
    endtask : wait_tx
    task automatic rx(input logic signed [15:0] v, input logic r);
        peer_master_model_i.send(v, r);
        cyc(4);
    endtask : rx
    task automatic end_of_test;
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (30000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) rd_chk(i[3:0], rst_exp[i]);
        rd_chk(4'hb, 16'h0000);
        chk(node, 8'h01);
        wr_reg(REG_TORQUE_GAIN, 16'h07d0);
        rd_chk(REG_TORQUE_GAIN, 16'h03e8);
        wr_reg(REG_SEND_PERIOD, 16'h0000);
        rd_chk(REG_SEND_PERIOD, 16'h0001);
        wr_reg(REG_LOSS_TIMEOUT, 16'h00c8);
        rd_chk(REG_LOSS_TIMEOUT, 16'h0064);
        ltorq <= 16'sd1234;
        lrun <= 1'b1;
        wr_reg(REG_CTRL, 16'h0100);
        wait_tx(n);
        chk(n, 300);
        wr_reg(REG_SEND_PERIOD, 16'h0002);
        wr_reg(REG_CTRL, 16'h0101);
        wait_tx(n);
        wait_tx(n);
        chk(n + 1, 2 * TICK);
        chk(txf.value, 1234);
        chk(txf.run, 1);
        lfreq <= -16'sd321;
        wr_reg(REG_CTRL, 16'h0001);
        wait_tx(n);
        wait_tx(n);
        chk(txf.value, -321);
        wr_reg(REG_TORQUE_GAIN, RST_GAIN);
        wr_reg(REG_CTRL, 16'h0083);
        rx(16'sd10000, 1'b0);
        chk(tref, 2000);
        chk({trefv, frefv}, 2'b10);
        chk(node, 8'h02);
        wr_reg(REG_TORQUE_GAIN, 16'h00c8);
        rx(16'sd6000, 1'b0);
        chk(tref, 2000);
        rx(-16'sd6000, 1'b0);
        chk(tref, -2000);
        wr_reg(REG_TORQUE_GAIN, 16'hff9c);
        wr_reg(REG_TORQUE_OFFSET, 16'hfe0c);
        rx(16'sd3000, 1'b0);
        chk(tref, -700);
        rd_chk(REG_REF_OUT, 16'h0bb8);
        wr_reg(REG_CTRL, 16'h0003);
        cyc(2);
        chk(trefv, 0);
        wr_reg(REG_CTRL, 16'h004b);
        wr_reg(REG_FREQ_OFFSET, 16'h03e8);
        rx(16'sd4000, 1'b0);
        chk(fref, 2500);
        chk({trefv, frefv}, 2'b01);
        wr_reg(REG_FREQ_OFFSET, 16'h0000);
        rx(16'sd10000, 1'b0);
        chk(fref, 5000);
        wr_reg(REG_CTRL, 16'h00a7);
        cyc(2);
        chk(fact, 1);
        rx(16'sd0, 1'b1);
        chk(frun, 1);
        rx(16'sd0, 1'b0);
        chk(frun, 0);
        wr_reg(REG_CTRL, 16'h0097);
        cyc(2);
        chk(fact, 0);
        wr_reg(REG_CTRL, 16'h0083);
        wr_reg(REG_LOSS_TIMEOUT, 16'h0001);
        rx(16'sd0, 1'b0);
        cyc(700);
        chk(lfault, 0);
        rx(16'sd0, 1'b0);
        cyc(700);
        chk(lfault, 0);
        cyc(400);
        chk(lfault, 1);
        rd_chk(REG_STATUS, 16'h000a);
        wr_reg(REG_LOSS_TIMEOUT, 16'h0000);
        cyc(1200);
        chk(lfault, 0);
        lfreq <= 16'sh0000;
        wr_reg(REG_CTRL, 16'h0183);
        rx(16'sd5000, 1'b0);
        cyc(2);
        chk(rfault, 1);
        wr_reg(REG_RUNAWAY, 16'h0000);
        cyc(3);
        chk(rfault, 0);
        end_of_test();
    end
endmodule : drive_peer_reference_link_tb_top
`default_nettype wire
